// >>> logic/dfc_pkg.sv
// constants, types and register map shared by the flow and compare execution unit
package dfc_pkg;

   // ****************************************
   // widths and depths
   // ****************************************
   localparam int DFC_DATA_W     = 16;
   localparam int DFC_EXT_W      = 4;
   localparam int DFC_ACC_W      = 36;   // extension + high + low
   localparam int DFC_LOOP_DEPTH = 4;
   localparam int DFC_ADDR_W     = 6;

   // ****************************************
   // register map (word addresses on the register port)
   // ****************************************
   localparam logic [5:0] DFC_ADDR_PC        = 6'h00;
   localparam logic [5:0] DFC_ADDR_SP        = 6'h01;
   localparam logic [5:0] DFC_ADDR_ST0       = 6'h02;
   localparam logic [5:0] DFC_ADDR_ST1       = 6'h03;
   localparam logic [5:0] DFC_ADDR_LC        = 6'h04;
   localparam logic [5:0] DFC_ADDR_LOOP_FRST = 6'h05;
   localparam logic [5:0] DFC_ADDR_LOOP_LAST = 6'h06;
   localparam logic [5:0] DFC_ADDR_LOOP_CTL  = 6'h07;
   localparam logic [5:0] DFC_ADDR_ACC_BASE  = 6'h10;  // + acc*4 + part
   localparam logic [1:0] DFC_PART_LOW       = 2'h0;
   localparam logic [1:0] DFC_PART_HIGH      = 2'h1;
   localparam logic [1:0] DFC_PART_EXT       = 2'h2;

   // ****************************************
   // status field positions (first status register)
   // ****************************************
   localparam int DFC_FLAG_Z = 15;
   localparam int DFC_FLAG_M = 14;
   localparam int DFC_FLAG_N = 13;
   localparam int DFC_FLAG_V = 12;
   localparam int DFC_FLAG_C = 11;
   localparam int DFC_FLAG_E = 10;
   localparam int DFC_FLAG_L = 9;
   localparam int DFC_LOOP_ACTIVE_POS = 3;   // in the loop control read word

   // ****************************************
   // reset values and constants
   // ****************************************
   localparam logic [15:0] DFC_PC_RST     = 16'h0000;
   localparam logic [15:0] DFC_SP_RST     = 16'h0000;
   localparam logic [15:0] DFC_ST_RST     = 16'h0000;
   localparam logic [35:0] DFC_ROUND_CONST = 36'h0_0000_8000;

   // ****************************************
   // cycle and word counts
   // ****************************************
   localparam logic [1:0] DFC_CYC_ABS_TAKEN = 2'h3;
   localparam logic [1:0] DFC_CYC_ABS_NOT   = 2'h2;
   localparam logic [1:0] DFC_CYC_REL       = 2'h2;
   localparam logic [1:0] DFC_CYC_CALL_ACC  = 2'h2;
   localparam logic [1:0] DFC_CYC_ONE       = 2'h1;
   localparam logic [1:0] DFC_CYC_TWO       = 2'h2;
   localparam logic [15:0] DFC_WORDS_ONE    = 16'h0001;
   localparam logic [15:0] DFC_WORDS_TWO    = 16'h0002;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [3:0] {
      DFC_OP_NOP, DFC_OP_BRANCH_ABSOLUTE_OP, DFC_OP_BRANCH_REL, DFC_OP_LOOP_BREAK,
      DFC_OP_CALL_ABS, DFC_OP_CALL_ACC, DFC_OP_CALL_REL, DFC_OP_TOGGLE_FIELD,
      DFC_OP_ACC_CLEAR, DFC_OP_ACC_CLEAR_ROUND, DFC_OP_COMPARE, DFC_OP_COMPARE_UNS
   } dfc_op_t;

   typedef enum logic [2:0] {
      DFC_TGT_EXT, DFC_TGT_ST0, DFC_TGT_ST1, DFC_TGT_ACC_LOW, DFC_TGT_ACC_HIGH, DFC_TGT_ACC_EXT
   } dfc_tgt_t;

   typedef enum logic [0:0] {DFC_ST_IDLE = 1'b0, DFC_ST_HOLD = 1'b1} dfc_state_t;

   typedef struct packed {
      dfc_op_t            op;
      logic [3:0]         cond;       // condition code
      dfc_tgt_t           tgt;        // toggle target
      logic [1:0]         acc_sel;    // 0 a0, 1 a1, 2 b0, 3 b1
      logic               long_form;  // compare with a second word
      logic [15:0]        word2;      // target address or long immediate
      logic signed [7:0]  rel_off;    // -128 .. +127
      logic [15:0]        operand;    // memory or register operand
   } dfc_op_req_t;

   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [15:0] data;
   } dfc_stack_wr_t;

endpackage : dfc_pkg

// >>> logic/dfc_exec.sv
// program-flow, bit-field toggle, clear and compare execution unit
`timescale 1ns/1ns
module dfc_exec (
   // clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   rst_n_i,
   // decoded instruction stream
   input  wire logic                   op_valid_i,
   input  wire dfc_pkg::dfc_op_req_t   op_i,
   output logic                        op_ready_o,
   // software stack and operand write-back
   output dfc_pkg::dfc_stack_wr_t      stack_o,
   output logic [15:0]                 result_o,
   output logic                        result_we_o,
   output logic [15:0]                 pc_o,
   // register port
   input  wire logic [5:0]             reg_addr_i,
   input  wire logic [15:0]            reg_wdata_i,
   input  wire logic                   reg_we_i,
   input  wire logic                   reg_re_i,
   output logic [15:0]                 reg_rdata_o
);
   import dfc_pkg::*;

   // ****************************************
   // state
   // ****************************************
   dfc_state_t     state_r, state_nxt;
   logic [1:0]     cyc_r, cyc_nxt;
   logic [15:0]    pc_r, pc_nxt, sp_r, sp_nxt;
   logic [15:4]    st0_r, st0_nxt, st1_r, st1_nxt;
   logic [35:0]    acc_r [4];
   logic [35:0]    acc_nxt [4];
   logic [15:0]    lc_r, lc_nxt, stg_first_r, stg_first_nxt, stg_last_r, stg_last_nxt;
   logic [15:0]    lp_first_r [DFC_LOOP_DEPTH];
   logic [15:0]    lp_last_r [DFC_LOOP_DEPTH];
   logic [15:0]    lp_cnt_r [DFC_LOOP_DEPTH];
   logic [15:0]    lp_first_nxt [DFC_LOOP_DEPTH];
   logic [15:0]    lp_last_nxt [DFC_LOOP_DEPTH];
   logic [15:0]    lp_cnt_nxt [DFC_LOOP_DEPTH];
   logic [2:0]     depth_r, depth_nxt;
   logic           loop_active_bit_r, loop_active_nxt;
   dfc_stack_wr_t  stack_r, stack_nxt;
   logic [15:0]    result_r, result_nxt, rdata_r;
   logic           result_we_r, result_we_nxt;

   // ****************************************
   // decode
   // ****************************************
   wire         accept      = op_valid_i && (state_r == DFC_ST_IDLE);
   wire [15:0]  st0_view    = {st0_r, acc_r[0][35:32]};   // low nibble is a0 extension
   wire [15:0]  st1_view    = {st1_r, acc_r[1][35:32]};   // low nibble is a1 extension
   wire [1:0]   first_sel   = {1'b0, op_i.acc_sel[0]};
   wire [35:0]  acc_first   = acc_r[first_sel];
   wire [35:0]  acc_any     = acc_r[op_i.acc_sel];
   wire [15:0]  pc_plus1    = pc_r + DFC_WORDS_ONE;
   wire [15:0]  pc_plus2    = pc_r + DFC_WORDS_TWO;
   wire [15:0]  pc_rel      = pc_plus1 + 16'(op_i.rel_off);
   wire [15:0]  sp_dec      = sp_r - DFC_WORDS_ONE;
   wire [2:0]   depth_dec   = depth_r - 3'h1;
   wire [1:0]   top_idx     = depth_dec[1:0];
   wire [1:0]   under_idx   = 2'(depth_r - 3'h2);
   wire         depth_full  = (depth_r == 3'(DFC_LOOP_DEPTH));

   // condition codes evaluated on the live flags
   wire         fz = st0_r[DFC_FLAG_Z];
   wire         fm = st0_r[DFC_FLAG_M];
   logic        cond_ok;
   always_comb begin
      case (op_i.cond)
         4'h0:    cond_ok = 1'b1;
         4'h1:    cond_ok = fz;
         4'h2:    cond_ok = !fz;
         4'h3:    cond_ok = !fm && !fz;
         4'h4:    cond_ok = !fm;
         4'h5:    cond_ok = fm;
         4'h6:    cond_ok = fm || fz;
         4'h7:    cond_ok = !st0_r[DFC_FLAG_N];
         4'h8:    cond_ok = st0_r[DFC_FLAG_V];
         4'h9:    cond_ok = st0_r[DFC_FLAG_C];
         4'ha:    cond_ok = st0_r[DFC_FLAG_E];
         4'hb:    cond_ok = st0_r[DFC_FLAG_L];
         default: cond_ok = 1'b0;
      endcase
   end

   // ****************************************
   // compare datapath
   // ****************************************
   wire         cmp_uns = (op_i.op == DFC_OP_COMPARE_UNS);
   wire [35:0]  cmp_opx = cmp_uns ? {20'h0_0000, op_i.operand}
                                  : {{20{op_i.operand[15]}}, op_i.operand};
   wire [36:0]  cmp_raw = {1'b0, acc_first} - {1'b0, cmp_opx};
   wire [35:0]  cmp_d   = cmp_raw[35:0];                 // difference is discarded
   wire         cmp_ext = !((&cmp_d[35:31]) || !(|cmp_d[35:31]));
   wire         cmp_v   = (acc_first[35] ^ cmp_opx[35]) && (cmp_d[35] ^ acc_first[35]);

   // ****************************************
   // toggle datapath: 16-bit operand, no sign extension anywhere
   // ****************************************
   logic [15:0] tog_src;
   always_comb begin
      case (op_i.tgt)
         DFC_TGT_ST0:      tog_src = st0_view;
         DFC_TGT_ST1:      tog_src = st1_view;
         DFC_TGT_ACC_LOW:  tog_src = acc_any[15:0];
         DFC_TGT_ACC_HIGH: tog_src = acc_any[31:16];
         DFC_TGT_ACC_EXT:  tog_src = {12'h000, acc_any[35:32]};
         default:          tog_src = op_i.operand;
      endcase
   end
   wire [15:0]  tog_res = tog_src ^ op_i.word2;

   // ****************************************
   // register port decode
   // ****************************************
   wire         acc_hit  = (reg_addr_i[5:4] == DFC_ADDR_ACC_BASE[5:4]);
   wire [1:0]   acc_idx  = reg_addr_i[3:2];
   wire [1:0]   acc_part = reg_addr_i[1:0];
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;   // unmapped addresses read as zero
      if (acc_hit) begin
         case (acc_part)
            DFC_PART_LOW:  rd_mux = acc_r[acc_idx][15:0];
            DFC_PART_HIGH: rd_mux = acc_r[acc_idx][31:16];
            DFC_PART_EXT:  rd_mux = {12'h000, acc_r[acc_idx][35:32]};
            default:       rd_mux = 16'h0000;
         endcase
      end else begin
         case (reg_addr_i)
            DFC_ADDR_PC:        rd_mux = pc_r;
            DFC_ADDR_SP:        rd_mux = sp_r;
            DFC_ADDR_ST0:       rd_mux = st0_view;
            DFC_ADDR_ST1:       rd_mux = st1_view;
            DFC_ADDR_LC:        rd_mux = lc_r;
            DFC_ADDR_LOOP_FRST: rd_mux = (depth_r != 3'h0) ? lp_first_r[top_idx] : 16'h0000;
            DFC_ADDR_LOOP_LAST: rd_mux = (depth_r != 3'h0) ? lp_last_r[top_idx] : 16'h0000;
            DFC_ADDR_LOOP_CTL:  rd_mux = {12'h000, loop_active_bit_r, depth_r};
            default:            rd_mux = 16'h0000;
         endcase
      end
   end

   // ****************************************
   // next-state: bus writes first, then the accepted instruction on top
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      cyc_nxt = cyc_r;
      pc_nxt = pc_r;
      sp_nxt = sp_r;
      st0_nxt = st0_r;
      st1_nxt = st1_r;
      acc_nxt = acc_r;
      lc_nxt = lc_r;
      stg_first_nxt = stg_first_r;
      stg_last_nxt = stg_last_r;
      lp_first_nxt = lp_first_r;
      lp_last_nxt = lp_last_r;
      lp_cnt_nxt = lp_cnt_r;
      depth_nxt = depth_r;
      loop_active_nxt = loop_active_bit_r;
      stack_nxt = '0;
      result_nxt = result_r;
      result_we_nxt = 1'b0;

      // software writes
      if (reg_we_i && acc_hit) begin
         case (acc_part)
            DFC_PART_LOW:  acc_nxt[acc_idx][15:0] = reg_wdata_i;
            DFC_PART_HIGH: acc_nxt[acc_idx][31:16] = reg_wdata_i;
            DFC_PART_EXT:  acc_nxt[acc_idx][35:32] = reg_wdata_i[3:0];
            default:       ;
         endcase
      end else if (reg_we_i) begin
         case (reg_addr_i)
            DFC_ADDR_PC:        pc_nxt = reg_wdata_i;
            DFC_ADDR_SP:        sp_nxt = reg_wdata_i;
            DFC_ADDR_ST0:       begin
               st0_nxt = reg_wdata_i[15:4];
               acc_nxt[0][35:32] = reg_wdata_i[3:0];
            end
            DFC_ADDR_ST1:       begin
               st1_nxt = reg_wdata_i[15:4];
               acc_nxt[1][35:32] = reg_wdata_i[3:0];
            end
            DFC_ADDR_LOOP_FRST: stg_first_nxt = reg_wdata_i;
            DFC_ADDR_LOOP_LAST: stg_last_nxt = reg_wdata_i;
            DFC_ADDR_LOOP_CTL:  begin
               // push a loop level; a full stack or a same-cycle loop exit drops it
               if (!depth_full && !(accept && op_i.op == DFC_OP_LOOP_BREAK)) begin
                  lp_first_nxt[depth_r[1:0]] = stg_first_r;
                  lp_last_nxt[depth_r[1:0]] = stg_last_r;
                  lp_cnt_nxt[depth_r[1:0]] = reg_wdata_i;
                  depth_nxt = depth_r + 3'h1;
                  lc_nxt = reg_wdata_i;
                  loop_active_nxt = 1'b1;
               end
            end
            default:            ;
         endcase
      end

      // instruction execution, all effects land at the accept edge
      if (accept) begin
         pc_nxt = pc_plus1;
         cyc_nxt = DFC_CYC_ONE;
         case (op_i.op)
            DFC_OP_BRANCH_ABSOLUTE_OP, DFC_OP_CALL_ABS: begin
               pc_nxt = cond_ok ? op_i.word2 : pc_plus2;
               cyc_nxt = cond_ok ? DFC_CYC_ABS_TAKEN : DFC_CYC_ABS_NOT;
               if (cond_ok && op_i.op == DFC_OP_CALL_ABS) begin
                  sp_nxt = sp_dec;
                  stack_nxt = '{we: 1'b1, addr: sp_dec, data: pc_plus2};
               end
            end
            DFC_OP_BRANCH_REL: begin
               cyc_nxt = DFC_CYC_REL;
               if (cond_ok) pc_nxt = pc_rel;
            end
            DFC_OP_CALL_REL: begin
               cyc_nxt = DFC_CYC_REL;
               if (cond_ok) begin
                  pc_nxt = pc_rel;
                  sp_nxt = sp_dec;
                  stack_nxt = '{we: 1'b1, addr: sp_dec, data: pc_plus1};
               end
            end
            DFC_OP_CALL_ACC: begin
               cyc_nxt = DFC_CYC_CALL_ACC;
               pc_nxt = acc_first[15:0];
               sp_nxt = sp_dec;
               stack_nxt = '{we: 1'b1, addr: sp_dec, data: pc_plus1};
            end
            DFC_OP_LOOP_BREAK: begin
               if (depth_r != 3'h0) begin
                  depth_nxt = depth_dec;
                  if (depth_r == 3'h1) loop_active_nxt = 1'b0;
                  else lc_nxt = lp_cnt_r[under_idx];
               end
            end
            DFC_OP_TOGGLE_FIELD: begin
               pc_nxt = pc_plus2;
               cyc_nxt = DFC_CYC_TWO;
               st0_nxt[DFC_FLAG_Z] = (tog_res == 16'h0000);
               st0_nxt[DFC_FLAG_M] = tog_res[15];
               case (op_i.tgt)
                  DFC_TGT_ST0: begin
                     // the flag bits take the toggled word itself, then a0e follows
                     st0_nxt = tog_res[15:4];
                     acc_nxt[0][35:32] = tog_res[3:0];
                  end
                  DFC_TGT_ST1: begin
                     st1_nxt = tog_res[15:4];
                     acc_nxt[1][35:32] = tog_res[3:0];
                  end
                  DFC_TGT_ACC_LOW:  acc_nxt[op_i.acc_sel][15:0] = tog_res;
                  DFC_TGT_ACC_HIGH: acc_nxt[op_i.acc_sel][31:16] = tog_res;
                  DFC_TGT_ACC_EXT:  acc_nxt[op_i.acc_sel][35:32] = tog_res[3:0];
                  default: begin
                     result_nxt = tog_res;
                     result_we_nxt = 1'b1;
                  end
               endcase
            end
            DFC_OP_ACC_CLEAR: begin
               if (cond_ok) acc_nxt[op_i.acc_sel] = '0;
            end
            DFC_OP_ACC_CLEAR_ROUND: begin
               if (cond_ok) acc_nxt[first_sel] = DFC_ROUND_CONST;
            end
            DFC_OP_COMPARE, DFC_OP_COMPARE_UNS: begin
               // long forms only exist for the signed compare
               if (op_i.long_form && !cmp_uns) begin
                  pc_nxt = pc_plus2;
                  cyc_nxt = DFC_CYC_TWO;
               end
               st0_nxt[DFC_FLAG_Z] = (cmp_d == '0);
               st0_nxt[DFC_FLAG_M] = cmp_d[35];
               st0_nxt[DFC_FLAG_N] = !cmp_ext && (cmp_d[31] ^ cmp_d[30]);
               st0_nxt[DFC_FLAG_V] = cmp_v;
               st0_nxt[DFC_FLAG_C] = cmp_raw[36];
               st0_nxt[DFC_FLAG_E] = cmp_ext;
               st0_nxt[DFC_FLAG_L] = st0_r[DFC_FLAG_L] || cmp_v;
            end
            default: ;
         endcase
         state_nxt = (cyc_nxt == DFC_CYC_ONE) ? DFC_ST_IDLE : DFC_ST_HOLD;
         cyc_nxt = cyc_nxt - 2'h1;
      end else if (state_r == DFC_ST_HOLD) begin
         // extra cycles of multi-cycle instructions stall the stream
         cyc_nxt = cyc_r - 2'h1;
         if (cyc_r == 2'h1) state_nxt = DFC_ST_IDLE;
      end
   end

   // ****************************************
   // flip-flops
   // ****************************************
   // control and architectural registers
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_r <= DFC_ST_IDLE;
         cyc_r <= 2'h0;
         pc_r <= DFC_PC_RST;
         sp_r <= DFC_SP_RST;
         st0_r <= DFC_ST_RST[15:4];
         st1_r <= DFC_ST_RST[15:4];
         depth_r <= 3'h0;
         loop_active_bit_r <= 1'b0;
         lc_r <= 16'h0000;
         stack_r <= '0;
         result_we_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         cyc_r <= cyc_nxt;
         pc_r <= pc_nxt;
         sp_r <= sp_nxt;
         st0_r <= st0_nxt;
         st1_r <= st1_nxt;
         depth_r <= depth_nxt;
         loop_active_bit_r <= loop_active_nxt;
         lc_r <= lc_nxt;
         stack_r <= stack_nxt;
         result_we_r <= result_we_nxt;
         rdata_r <= reg_re_i ? rd_mux : 16'h0000;   // valid only the cycle after the strobe
      end
   end

   // data storage, cleared as well so nothing reads unknown
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         acc_r <= '{default: '0};
         lp_first_r <= '{default: '0};
         lp_last_r <= '{default: '0};
         lp_cnt_r <= '{default: '0};
         stg_first_r <= 16'h0000;
         stg_last_r <= 16'h0000;
         result_r <= 16'h0000;
      end else begin
         acc_r <= acc_nxt;
         lp_first_r <= lp_first_nxt;
         lp_last_r <= lp_last_nxt;
         lp_cnt_r <= lp_cnt_nxt;
         stg_first_r <= stg_first_nxt;
         stg_last_r <= stg_last_nxt;
         result_r <= result_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign op_ready_o  = (state_r == DFC_ST_IDLE);
   assign stack_o     = stack_r;
   assign result_o    = result_r;
   assign result_we_o = result_we_r;
   assign pc_o        = pc_r;
   assign reg_rdata_o = rdata_r;

endmodule : dfc_exec

// >>> tb/dfc_exec_properties.sv
// port assertions for the flow and compare unit
`timescale 1ns/1ns
module dfc_exec_properties import dfc_pkg::*; (
   // clock and reset
   input wire logic                   sys_clk_i,
   input wire logic                   rst_n_i,
   // instruction side
   input wire logic                   op_valid_i,
   input wire dfc_pkg::dfc_op_req_t   op_i,
   input wire logic                   op_ready_o,
   // results
   input wire dfc_pkg::dfc_stack_wr_t stack_o,
   input wire logic [15:0]            result_o,
   input wire logic                   result_we_o,
   input wire logic [15:0]            pc_o
);
   // ****
   // helpers
   // ****
   wire logic acc_w = op_valid_i && op_ready_o;  // taken at this edge
   wire logic go_w  = op_i.cond == 4'h0;         // always
   wire logic no_w  = op_i.cond == 4'hf;         // never
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ready gaps after acceptance
   sequence stall_1; !op_ready_o ##1 op_ready_o; endsequence
   sequence stall_2; !op_ready_o [*2] ##1 op_ready_o; endsequence
   abs_jump_a: assert property (
      acc_w && go_w && op_i.op == DFC_OP_BRANCH_ABSOLUTE_OP
      |=> pc_o == $past(op_i.word2) ##0 stall_2) else $error("taken branch wrong");
   abs_skip_a: assert property (
      acc_w && no_w && op_i.op inside {DFC_OP_BRANCH_ABSOLUTE_OP, DFC_OP_CALL_ABS}
      |=> pc_o == $past(pc_o) + 16'h0002 && !stack_o.we ##0 stall_1) else $error("skip wrong");
   rel_jump_a: assert property (
      acc_w && go_w && op_i.op == DFC_OP_BRANCH_REL
      |=> pc_o == $past(pc_o) + 16'($past(op_i.rel_off)) + 16'h0001 ##0 stall_1)
      else $error("relative branch wrong");
   abs_call_a: assert property (
      acc_w && go_w && op_i.op == DFC_OP_CALL_ABS |=> stack_o.we
      && stack_o.data == $past(pc_o) + 16'h0002 && pc_o == $past(op_i.word2) ##0 stall_2)
      else $error("absolute call wrong");
   acc_call_a: assert property (
      acc_w && op_i.op == DFC_OP_CALL_ACC |=> stack_o.we && stack_o.data == $past(pc_o) + 16'h0001)
      else $error("accumulator call push wrong");
   rel_call_a: assert property (
      acc_w && go_w && op_i.op == DFC_OP_CALL_REL
      |=> stack_o.we && stack_o.data == $past(pc_o) + 16'h0001 ##0 stall_1)
      else $error("relative call wrong");
   toggle_out_a: assert property (
      acc_w && op_i.op == DFC_OP_TOGGLE_FIELD && op_i.tgt == DFC_TGT_EXT |=> result_we_o
      && result_o == ($past(op_i.operand) ^ $past(op_i.word2)) ##0 stall_1)
      else $error("toggle result wrong");
   cmp_single_a: assert property (
      acc_w && (op_i.op == DFC_OP_COMPARE_UNS || op_i.op == DFC_OP_COMPARE && !op_i.long_form)
      |=> op_ready_o) else $error("short compare stalled");
   cmp_long_a: assert property (
      acc_w && op_i.op == DFC_OP_COMPARE && op_i.long_form
      |=> pc_o == $past(pc_o) + 16'h0002 ##0 stall_1) else $error("long compare wrong");
endmodule : dfc_exec_properties

bind dfc_exec dfc_exec_properties u_dfc_exec_properties (.sys_clk_i(sys_clk_i),
   .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_i(op_i), .op_ready_o(op_ready_o),
   .stack_o(stack_o), .result_o(result_o), .result_we_o(result_we_o), .pc_o(pc_o));

// >>> tb/dfc_exec_tb.sv
// self-checking bench for the flow and compare unit
`timescale 1ns/1ns
module dfc_exec_tb;
   import dfc_pkg::*;
   // ****
   // stimulus and observation
   // ****
   logic          sys_clk_i = 1'b0;
   logic          rst_n_i = 1'b0;
   logic          op_valid_i = 1'b0;
   dfc_op_req_t   op_i = '0;
   logic [5:0]    reg_addr_i = 6'h00;
   logic [15:0]   reg_wdata_i = 16'h0000;
   logic          reg_we_i = 1'b0;
   logic          reg_re_i = 1'b0;
   logic          lf = 1'b0;   // long form flag of the next instruction
   logic          op_ready_o, result_we_o, res_we;
   dfc_stack_wr_t stack_o, stk;
   logic [15:0]   result_o, pc_o, reg_rdata_o, rd;
   int            mismatches = 0, tests_run = 0, n;
   always #4 sys_clk_i = ~sys_clk_i;
   dfc_exec u_dfc_exec (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i),
      .op_i(op_i), .op_ready_o(op_ready_o), .stack_o(stack_o), .result_o(result_o),
      .result_we_o(result_we_o), .pc_o(pc_o), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
      .reg_rdata_o(reg_rdata_o));
   // ****
   // shared tasks
   // ****
   task stop_test;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test
   task chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_we_i <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task rdc(input logic [5:0] a, input logic [15:0] e);
      @(posedge sys_clk_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_re_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(reg_rdata_o, e);
   endtask : rdc
   // one instruction; n counts its cycles, a stuck ready ends the run
   task run(input dfc_op_t o, input logic [3:0] c, input dfc_tgt_t t, input logic [1:0] s,
            input logic [15:0] w, input logic [7:0] r, input logic [15:0] d);
      @(posedge sys_clk_i);
      op_valid_i <= 1'b1;
      op_i <= '{o, c, t, s, lf, w, r, d};
      @(posedge sys_clk_i);
      op_valid_i <= 1'b0;
      @(negedge sys_clk_i);
      stk = stack_o;
      res_we = result_we_o;
      for (n = 1; n < 9 && op_ready_o !== 1'b1; n++) @(negedge sys_clk_i);
      if (n == 9) begin
         mismatches++;
         $display("[ERR] %0t ready %h exp %h", $time, op_ready_o, 1'b1);
         stop_test();
      end
   endtask : run
   // ****
   // scenarios
   // ****
   task t_flow;
      rdc(6'h3f, 16'h0000);
      run(DFC_OP_BRANCH_ABSOLUTE_OP, 4'h0, DFC_TGT_EXT, 2'h0, 16'h0100, 8'h00, 16'h0000);
      chk(pc_o, 16'h0100);
      chk(16'(n), 16'h0003);
      run(DFC_OP_BRANCH_ABSOLUTE_OP, 4'hf, DFC_TGT_EXT, 2'h0, 16'h0300, 8'h00, 16'h0000);
      chk(pc_o, 16'h0102);
      chk(16'(n), 16'h0002);
      run(DFC_OP_BRANCH_REL, 4'h0, DFC_TGT_EXT, 2'h0, 16'h0000, 8'hc1, 16'h0000);
      chk(pc_o, 16'h00c4);
   endtask : t_flow
   task t_calls;
      wr(6'h10, 16'h0abc);
      run(DFC_OP_CALL_ABS, 4'h0, DFC_TGT_EXT, 2'h0, 16'h0200, 8'h00, 16'h0000);
      chk(stk.addr, 16'hffff);
      chk(stk.data, 16'h00c6);
      run(DFC_OP_CALL_REL, 4'h0, DFC_TGT_EXT, 2'h0, 16'h0000, 8'h40, 16'h0000);
      chk(pc_o, 16'h0241);
      run(DFC_OP_CALL_ACC, 4'hf, DFC_TGT_EXT, 2'h0, 16'h0000, 8'h00, 16'h0000);
      chk(stk.addr, 16'hfffd);
      chk(pc_o, 16'h0abc);
   endtask : t_calls
   task t_toggle;
      wr(6'h11, 16'h1234);
      run(DFC_OP_TOGGLE_FIELD, 4'h0, DFC_TGT_ACC_LOW, 2'h0, 16'h00ff, 8'h00, 16'h0000);
      rdc(6'h10, 16'h0a43);
      rdc(6'h11, 16'h1234);
      run(DFC_OP_TOGGLE_FIELD, 4'h0, DFC_TGT_EXT, 2'h0, 16'hffff, 8'h00, 16'h8001);
      chk({15'h0000, res_we}, 16'h0001);
      chk(result_o, 16'h7ffe);
      // second status: the a1 extension moves, the zero and minus flags follow the result
      run(DFC_OP_TOGGLE_FIELD, 4'h0, DFC_TGT_ST1, 2'h0, 16'h8003, 8'h00, 16'h0000);
      rdc(6'h03, 16'h8003);
      rdc(6'h16, 16'h0003);
      rdc(6'h02, 16'h4000);
      // first status: the toggled word itself lands, a0 extension included
      run(DFC_OP_TOGGLE_FIELD, 4'h0, DFC_TGT_ST0, 2'h0, 16'h0001, 8'h00, 16'h0000);
      rdc(6'h02, 16'h4001);
   endtask : t_toggle
   task t_clear;
      wr(6'h18, 16'h5555);
      run(DFC_OP_ACC_CLEAR, 4'hf, DFC_TGT_EXT, 2'h2, 16'h0000, 8'h00, 16'h0000);
      rdc(6'h18, 16'h5555);
      run(DFC_OP_ACC_CLEAR, 4'h0, DFC_TGT_EXT, 2'h2, 16'h0000, 8'h00, 16'h0000);
      rdc(6'h18, 16'h0000);
      run(DFC_OP_ACC_CLEAR_ROUND, 4'h0, DFC_TGT_EXT, 2'h1, 16'h0000, 8'h00, 16'h0000);
      rdc(6'h14, 16'h8000);
   endtask : t_clear
   // zero minus all-ones: signed gives plus one, unsigned goes negative
   task t_cmp;
      run(DFC_OP_ACC_CLEAR, 4'h0, DFC_TGT_EXT, 2'h0, 16'h0000, 8'h00, 16'h0000);
      run(DFC_OP_COMPARE, 4'h0, DFC_TGT_EXT, 2'h0, 16'h0000, 8'h00, 16'hffff);
      rdc(6'h02, 16'h0800);
      run(DFC_OP_COMPARE_UNS, 4'h0, DFC_TGT_EXT, 2'h0, 16'h0000, 8'h00, 16'hffff);
      rdc(6'h02, 16'h4800);
      // long signed form: two words, two cycles, equal operands give zero
      lf = 1'b1;
      rd = pc_o;
      run(DFC_OP_COMPARE, 4'h0, DFC_TGT_EXT, 2'h0, 16'h0000, 8'h00, 16'h0000);
      lf = 1'b0;
      chk(16'(n), 16'h0002);
      chk(pc_o, rd + 16'h0002);
      rdc(6'h02, 16'h8000);
   endtask : t_cmp
   task t_loop;
      wr(6'h07, 16'h0005);
      run(DFC_OP_LOOP_BREAK, 4'h0, DFC_TGT_EXT, 2'h0, 16'h0000, 8'h00, 16'h0000);
      chk(16'(n), 16'h0001);
      rdc(6'h04, 16'h0005);
      rdc(6'h07, 16'h0000);
   endtask : t_loop
   initial begin
      repeat (16) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_flow();
      t_calls();
      t_toggle();
      t_clear();
      t_cmp();
      t_loop();
      stop_test();
   end
endmodule : dfc_exec_tb
